// ---- sim/test_nmi_and_sleep_power_control.sv ----
`timescale 1ns/1ns
module test_nmi_and_sleep_power_control;
  import npc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] hw_ev = 3'h0;
  logic [1:0] bor_cfg = 2'h1;
  logic sleep = 1'b0;
  logic nmi_o, nmi_event_o, frc_switch_o, device_reset_o;
  logic bor_off, retention, standby;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int ev_cnt = 0;
  int rst_cnt = 0;
  int frc_cnt = 0;
  int n, e0, r0, f0;
  int bits[4] = '{23, 19, 17, 16};
  int hw_bit[3] = '{24, 16, 17};

  npc_nmi_power dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_run_timeout_i(hw_ev[0]), .wdt_sleep_timeout_i(hw_ev[1]),
    .clk_fail_detect_i(hw_ev[2]), .brownout_config_setting_i(bor_cfg),
    .sleep_i(sleep), .nmi_o(nmi_o), .nmi_event_o(nmi_event_o),
    .frc_switch_o(frc_switch_o), .device_reset_o(device_reset_o),
    .sleep_bor_off_o(bor_off), .reg_retention_o(retention),
    .reg_standby_o(standby));

  always #20 clk_i = ~clk_i;

  // ==========================================================
  // Pulse counters and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (nmi_event_o === 1'b1) ev_cnt++;
    if (device_reset_o === 1'b1) rst_cnt++;
    if (frc_switch_o === 1'b1) frc_cnt++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // Tasks
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    hw_ev[i] <= 1'b1;
    @(posedge clk_i);
    hw_ev <= 3'h0;
  endtask

  task automatic wait_rst(output int c);
    c = 0;
    do begin
      @(negedge clk_i);
      c++;
    end while (device_reset_o !== 1'b1 && c < 60);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(NMI_CTRL_OFS, 32'h0);
    rd(PWR_CTRL_OFS, 32'h0);
    wr(PWR_CTRL_OFS, 32'h7);
    wr(NMI_CTRL_OFS, 32'h0080_0000);
    rd(PWR_CTRL_OFS, 32'h0);
    rd(NMI_CTRL_OFS, 32'h0);
    rd(8'h30, 32'h0);
    check(32'(rerr), 32'h1);
    wr(UNLOCK_OFS, UNLOCK_KEY1);
    wr(UNLOCK_OFS, UNLOCK_KEY2);
    wr(PWR_CTRL_OFS, 32'hffff_ffff);
    rd(PWR_CTRL_OFS, 32'h7);
    wr(NMI_CTRL_OFS, 32'hfe74_ffff);
    rd(NMI_CTRL_OFS, 32'h0000_ffff);
    // Power outputs during Sleep
    sleep <= 1'b1;
    wr(PWR_CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk_i);
    check(32'({bor_off, retention, standby}), 32'h5);
    wr(PWR_CTRL_OFS + 8'h08, 32'h7);
    rd(PWR_CTRL_OFS, 32'h7);
    check(32'({bor_off, retention, standby}), 32'h2);
    bor_cfg <= 2'h0;
    wr(PWR_CTRL_OFS + 8'h04, 32'h4);
    rd(PWR_CTRL_OFS, 32'h3);
    check(32'({bor_off, retention, standby}), 32'h2);
    wr(PWR_CTRL_OFS + 8'h0c, 32'h3);
    rd(PWR_CTRL_OFS, 32'h0);
    check(32'({bor_off, retention, standby}), 32'h1);
    sleep <= 1'b0;
    bor_cfg <= 2'h1;
    // Software sources: no countdown, cleared through the clear alias
    foreach (bits[i]) begin
      wr(NMI_CTRL_OFS, 32'h0);
      e0 = ev_cnt;
      r0 = rst_cnt;
      f0 = frc_cnt;
      wr(NMI_CTRL_OFS + 8'h08, 32'h1 << bits[i]);
      rd(NMI_CTRL_OFS, 32'h1 << bits[i]);
      check(32'(nmi_o), 32'h1);
      wr(NMI_CTRL_OFS + 8'h04, 32'h1 << bits[i]);
      repeat (5) @(posedge clk_i);
      check(32'(nmi_o), 32'h0);
      check(32'(ev_cnt - e0), 32'h1);
      check(32'(rst_cnt - r0), 32'h0);
      check(32'(frc_cnt - f0), 32'h0);
    end
    // Software run trigger with reload 0 and 3
    for (int r = 0; r < 4; r += 3) begin
      wr(NMI_CTRL_OFS, 32'(r));
      wr(NMI_CTRL_OFS + 8'h08, 32'h0100_0000);
      wait_rst(n);
      check(32'(n), 32'(r + 1));
    end
    // Cleared before the count runs out
    wr(NMI_CTRL_OFS, 32'h14);
    r0 = rst_cnt;
    wr(NMI_CTRL_OFS + 8'h08, 32'h0100_0000);
    wr(NMI_CTRL_OFS + 8'h04, 32'h0100_0000);
    repeat (40) @(posedge clk_i);
    check(32'(rst_cnt - r0), 32'h0);
    // Hardware sources with reload 7
    foreach (hw_bit[i]) begin
      wr(NMI_CTRL_OFS, 32'h7);
      f0 = frc_cnt;
      pulse(i);
      wait_rst(n);
      check(32'(n), (i == 0) ? 32'd8 : 32'd60);
      rd(NMI_CTRL_OFS, (32'h1 << hw_bit[i]) | 32'h7);
      check(32'(frc_cnt - f0), (i == 2) ? 32'h1 : 32'h0);
    end
    // Relock then writes are dropped
    wr(NMI_CTRL_OFS, 32'h0);
    wr(PWR_CTRL_OFS, 32'h2);
    wr(UNLOCK_OFS, 32'h0);
    rd(UNLOCK_OFS, 32'h0);
    wr(PWR_CTRL_OFS, 32'h5);
    rd(PWR_CTRL_OFS, 32'h2);
    complete_run();
  end
endmodule

// ---- src/npc_nmi_power.sv ----
`timescale 1ns/1ns
module npc_nmi_power (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdt_run_timeout_i,
  input wire logic wdt_sleep_timeout_i,
  input wire logic clk_fail_detect_i,
  input wire logic [1:0] brownout_config_setting_i,
  input wire logic sleep_i,
  output logic nmi_o,
  output logic nmi_event_o,
  output logic frc_switch_o,
  output logic device_reset_o,
  output logic sleep_bor_off_o,
  output logic reg_retention_o,
  output logic reg_standby_o
);
  import npc_pkg::*;

  // ==========================================================
  // Bus decode
  logic setup_w;
  logic wr_w;
  logic sel_nmi_w;
  logic sel_pwr_w;
  logic sel_key_w;
  logic prot_w;
  logic [1:0] alias_w;
  npc_lock_e lock_q;
  logic unlocked_w;
  assign setup_w = psel & ~penable;
  assign wr_w = psel & penable & pwrite & pready;
  assign sel_nmi_w = (paddr[7:4] == NMI_CTRL_OFS[7:4]) & (paddr[1:0] == 2'h0);
  assign sel_pwr_w = (paddr[7:4] == PWR_CTRL_OFS[7:4]) & (paddr[1:0] == 2'h0);
  assign sel_key_w = (paddr == UNLOCK_OFS);
  assign alias_w = paddr[3:2];
  assign unlocked_w = (lock_q == NPC_UNLOCKED);
  assign prot_w = wr_w & unlocked_w;

  function automatic logic [31:0] alias_apply(input logic [31:0] cur,
      input logic [31:0] wd, input logic [1:0] op);
    case (op)
      ALIAS_CLR: alias_apply = cur & ~wd;
      ALIAS_SET: alias_apply = cur | wd;
      ALIAS_INV: alias_apply = cur ^ wd;
      default: alias_apply = wd;
    endcase
  endfunction

  // ==========================================================
  // Unlock sequence
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_q <= NPC_LOCKED;
    end else if (wr_w && sel_key_w) begin
      case (lock_q)
        NPC_LOCKED: lock_q <= (pwdata == UNLOCK_KEY1) ? NPC_KEY1_SEEN
                                                       : NPC_LOCKED;
        NPC_KEY1_SEEN: lock_q <= (pwdata == UNLOCK_KEY2) ? NPC_UNLOCKED
                                                          : NPC_LOCKED;
        default: lock_q <= NPC_LOCKED;
      endcase
    end
  end

  // ==========================================================
  // NMI control register
  logic run_wdt_q;
  logic sw_nmi_q;
  logic gen_nmi_q;
  logic clk_fail_q;
  logic sleep_wdt_q;
  logic [15:0] reload_q;
  logic [31:0] nmi_rd_w;
  logic [31:0] nmi_new_w;
  logic nmi_wr_w;
  logic [31:0] nmi_rise_w;
  logic run_evt_w;
  logic any_evt_w;
  logic run_wdt_d;
  logic sw_nmi_d;
  logic gen_nmi_d;
  logic clk_fail_d;
  logic sleep_wdt_d;

  assign nmi_rd_w = {7'h0, run_wdt_q, sw_nmi_q, 3'h0, gen_nmi_q, 1'b0,
                     clk_fail_q, sleep_wdt_q, reload_q};
  assign nmi_new_w = alias_apply(nmi_rd_w, pwdata, alias_w) & NMI_CTRL_MASK;
  assign nmi_wr_w = prot_w & sel_nmi_w;
  assign nmi_rise_w = nmi_wr_w ? (nmi_new_w & ~nmi_rd_w) : 32'h0;
  assign run_evt_w = wdt_run_timeout_i | nmi_rise_w[RUN_WDT_BIT];
  assign any_evt_w = run_evt_w | (|nmi_rise_w[SW_NMI_BIT:SLEEP_WDT_BIT])
                   | wdt_sleep_timeout_i | clk_fail_detect_i;

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    run_wdt_d = nmi_wr_w ? nmi_new_w[RUN_WDT_BIT] : run_wdt_q;
    sw_nmi_d = nmi_wr_w ? nmi_new_w[SW_NMI_BIT] : sw_nmi_q;
    gen_nmi_d = nmi_wr_w ? nmi_new_w[GEN_NMI_BIT] : gen_nmi_q;
    clk_fail_d = nmi_wr_w ? nmi_new_w[CLK_FAIL_BIT] : clk_fail_q;
    sleep_wdt_d = nmi_wr_w ? nmi_new_w[SLEEP_WDT_BIT] : sleep_wdt_q;
    if (wdt_run_timeout_i) begin
      run_wdt_d = 1'b1;
    end
    if (clk_fail_detect_i) begin
      clk_fail_d = 1'b1;
    end
    if (wdt_sleep_timeout_i) begin
      sleep_wdt_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_wdt_q <= NMI_CTRL_RST[RUN_WDT_BIT];
      sw_nmi_q <= NMI_CTRL_RST[SW_NMI_BIT];
      gen_nmi_q <= NMI_CTRL_RST[GEN_NMI_BIT];
      clk_fail_q <= NMI_CTRL_RST[CLK_FAIL_BIT];
      sleep_wdt_q <= NMI_CTRL_RST[SLEEP_WDT_BIT];
      reload_q <= NMI_CTRL_RST[RELOAD_MSB:0];
    end else begin
      run_wdt_q <= run_wdt_d;
      sw_nmi_q <= sw_nmi_d;
      gen_nmi_q <= gen_nmi_d;
      clk_fail_q <= clk_fail_d;
      sleep_wdt_q <= sleep_wdt_d;
      if (nmi_wr_w) begin
        reload_q <= nmi_new_w[RELOAD_MSB:0];
      end
    end
  end

  // NMI request level and event pulses
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nmi_o <= 1'b0;
      nmi_event_o <= 1'b0;
      frc_switch_o <= 1'b0;
    end else begin
      nmi_o <= run_wdt_d | sw_nmi_d | gen_nmi_d | clk_fail_d
             | sleep_wdt_d;
      nmi_event_o <= any_evt_w;
      frc_switch_o <= clk_fail_detect_i;
    end
  end

  // ==========================================================
  // NMI reset countdown, watchdog run events only
  logic cnt_act_q;
  logic [15:0] cnt_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_act_q <= 1'b0;
      cnt_q <= 16'h0;
      device_reset_o <= 1'b0;
    end else begin
      device_reset_o <= 1'b0;
      if (run_evt_w) begin
        cnt_q <= reload_q;
        cnt_act_q <= (reload_q != 16'h0);
        device_reset_o <= (reload_q == 16'h0);
      end else if (cnt_act_q && !run_wdt_q) begin
        cnt_act_q <= 1'b0;
      end else if (cnt_act_q) begin
        cnt_q <= cnt_q - 16'h1;
        if (cnt_q == 16'h1) begin
          cnt_act_q <= 1'b0;
          device_reset_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Power control register
  logic [2:0] pwr_q;
  logic [31:0] pwr_new_w;
  assign pwr_new_w = alias_apply({29'h0, pwr_q}, pwdata, alias_w)
                   & PWR_CTRL_MASK;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q <= PWR_CTRL_RST;
    end else if (prot_w && sel_pwr_w) begin
      pwr_q <= pwr_new_w[2:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sleep_bor_off_o <= 1'b0;
      reg_retention_o <= 1'b0;
      reg_standby_o <= 1'b0;
    end else begin
      sleep_bor_off_o <= sleep_i & ~pwr_q[SLEEP_BOR_BIT]
                       & (brownout_config_setting_i == BOR_CFG_SW);
      reg_retention_o <= sleep_i & pwr_q[RETENTION_BIT];
      reg_standby_o <= sleep_i & ~pwr_q[REG_ACTIVE_BIT];
    end
  end

  // ==========================================================
  // Bus answer, captured in the setup cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_w;
      pslverr <= setup_w & ~(sel_nmi_w | sel_pwr_w | sel_key_w);
      if (setup_w && !pwrite) begin
        if (sel_nmi_w) begin
          prdata <= nmi_rd_w;
        end else if (sel_pwr_w) begin
          prdata <= {29'h0, pwr_q};
        end else if (sel_key_w) begin
          prdata <= {31'h0, unlocked_w};
        end else begin
          prdata <= 32'h0;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_run_evt_zero;
    run_evt_w && (reload_q == 16'h0);
  endsequence
  sequence s_last_count;
    cnt_act_q && run_wdt_q && !run_evt_w && (cnt_q == 16'h1);
  endsequence

  property p_run_set;
    @(posedge clk_i) disable iff (!arst_n_i)
    wdt_run_timeout_i |=> run_wdt_q && nmi_o;
  endproperty
  a_run_set: assert property (p_run_set) else $error("run flag");

  property p_sw_nmi;
    @(posedge clk_i) disable iff (!arst_n_i)
    nmi_wr_w && nmi_new_w[SW_NMI_BIT] |=> sw_nmi_q && nmi_o;
  endproperty
  a_sw_nmi: assert property (p_sw_nmi) else $error("sw nmi");

  property p_gen_nmi;
    @(posedge clk_i) disable iff (!arst_n_i)
    nmi_wr_w && nmi_new_w[GEN_NMI_BIT] |=> gen_nmi_q && nmi_o;
  endproperty
  a_gen_nmi: assert property (p_gen_nmi) else $error("gen nmi");

  property p_cf_sw;
    @(posedge clk_i) disable iff (!arst_n_i)
    nmi_rise_w[CLK_FAIL_BIT] && !clk_fail_detect_i
      |=> nmi_event_o && !frc_switch_o;
  endproperty
  a_cf_sw: assert property (p_cf_sw) else $error("cf switch");

  property p_zero_reload;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_run_evt_zero |=> device_reset_o;
  endproperty
  a_zero_reload: assert property (p_zero_reload) else $error("zero");

  property p_count_end;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_last_count |=> device_reset_o ##1 !device_reset_o;
  endproperty
  a_count_end: assert property (p_count_end) else $error("count");

  property p_reset_cause;
    @(posedge clk_i) disable iff (!arst_n_i)
    device_reset_o |-> $past(run_evt_w) || $past(run_wdt_q);
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("cause");

  property p_locked;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_w && !unlocked_w |=> $stable(pwr_q) && $stable(reload_q);
  endproperty
  a_locked: assert property (p_locked) else $error("locked");

  property p_set_alias;
    @(posedge clk_i) disable iff (!arst_n_i)
    prot_w && sel_pwr_w && (alias_w == ALIAS_SET)
      |=> pwr_q == ($past(pwr_q) | $past(pwdata[2:0]));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set");

  property p_slp_set;
    @(posedge clk_i) disable iff (!arst_n_i)
    wdt_sleep_timeout_i |=> sleep_wdt_q && nmi_o && nmi_event_o;
  endproperty
  a_slp_set: assert property (p_slp_set) else $error("slp");

  property p_cf_set;
    @(posedge clk_i) disable iff (!arst_n_i)
    clk_fail_detect_i |=> clk_fail_q && frc_switch_o;
  endproperty
  a_cf_set: assert property (p_cf_set) else $error("cf set");

  property p_slp_sw;
    @(posedge clk_i) disable iff (!arst_n_i)
    nmi_rise_w[SLEEP_WDT_BIT] |=> nmi_event_o && sleep_wdt_q;
  endproperty
  a_slp_sw: assert property (p_slp_sw) else $error("slp sw");

  property p_run_sw;
    @(posedge clk_i) disable iff (!arst_n_i)
    nmi_rise_w[RUN_WDT_BIT] |=> nmi_event_o && (cnt_q == $past(reload_q));
  endproperty
  a_run_sw: assert property (p_run_sw) else $error("run sw");

  property p_no_cnt;
    @(posedge clk_i) disable iff (!arst_n_i)
    !run_evt_w && !cnt_act_q |=> !device_reset_o;
  endproperty
  a_no_cnt: assert property (p_no_cnt) else $error("no cnt");

  property p_cancel;
    @(posedge clk_i) disable iff (!arst_n_i)
    cnt_act_q && !run_wdt_q && !run_evt_w |=> !cnt_act_q && !device_reset_o;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel");

  property p_nmi_lvl;
    @(posedge clk_i) disable iff (!arst_n_i)
    nmi_o == (run_wdt_q || sw_nmi_q || gen_nmi_q || clk_fail_q
              || sleep_wdt_q);
  endproperty
  a_nmi_lvl: assert property (p_nmi_lvl) else $error("nmi level");

  property p_pwr_rd;
    @(posedge clk_i) disable iff (!arst_n_i)
    setup_w && !pwrite && sel_pwr_w |=> prdata[31:3] == 29'h0;
  endproperty
  a_pwr_rd: assert property (p_pwr_rd) else $error("pwr read");

  property p_retain;
    @(posedge clk_i) disable iff (!arst_n_i)
    sleep_i && pwr_q[RETENTION_BIT] |=> reg_retention_o;
  endproperty
  a_retain: assert property (p_retain) else $error("retain");

  property p_stby;
    @(posedge clk_i) disable iff (!arst_n_i)
    sleep_i && !pwr_q[REG_ACTIVE_BIT] |=> reg_standby_o;
  endproperty
  a_stby: assert property (p_stby) else $error("standby");

  property p_bor_cfg;
    @(posedge clk_i) disable iff (!arst_n_i)
    (brownout_config_setting_i != BOR_CFG_SW)
      |=> !sleep_bor_off_o;
  endproperty
  a_bor_cfg: assert property (p_bor_cfg) else $error("bor cfg");
endmodule

// ---- src/npc_pkg.sv ----
package npc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] NMI_CTRL_OFS = 8'h00;
  localparam logic [7:0] PWR_CTRL_OFS = 8'h10;
  localparam logic [7:0] UNLOCK_OFS = 8'h20;
  // Alias selectors in address bits 3:2
  localparam logic [1:0] ALIAS_WR = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // ==========================================================
  // Field positions of the NMI control register
  localparam int RUN_WDT_BIT = 24;
  localparam int SW_NMI_BIT = 23;
  localparam int GEN_NMI_BIT = 19;
  localparam int CLK_FAIL_BIT = 17;
  localparam int SLEEP_WDT_BIT = 16;
  localparam int RELOAD_MSB = 15;
  localparam logic [31:0] NMI_CTRL_MASK = 32'h018b_ffff;
  // Field positions of the power control register
  localparam int SLEEP_BOR_BIT = 2;
  localparam int RETENTION_BIT = 1;
  localparam int REG_ACTIVE_BIT = 0;
  localparam logic [31:0] PWR_CTRL_MASK = 32'h0000_0007;
  // ==========================================================
  // Reset values and constants
  localparam logic [31:0] NMI_CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] PWR_CTRL_RST = 3'h0;
  localparam logic [1:0] BOR_CFG_SW = 2'h1;
  // Unlock keys, values arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'h0000_a5c3;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h0000_3c5a;
  typedef enum logic [1:0] {
    NPC_LOCKED,
    NPC_KEY1_SEEN,
    NPC_UNLOCKED
  } npc_lock_e;
endpackage
